// [verilog/isc_pkg.sv]
package isc_pkg;
  // register bus
  localparam int          ADDR_W          = 4;
  localparam int          DATA_W          = 4;
  localparam logic [3:0]  OFS_MASK        = 4'h0;
  localparam logic [3:0]  OFS_STATUS      = 4'h1;
  localparam logic [3:0]  OFS_CTRL        = 4'h2;
  localparam logic [3:0]  OFS_MODE        = 4'h3;
  // mask bank fields
  localparam int          MASK_EXT_BIT    = 0;
  localparam int          MASK_DIV_BIT    = 2;
  localparam logic [3:0]  MASK_RST        = 4'h0;
  // status fields
  localparam int          ST_EXT_BIT      = 0;
  localparam int          ST_DIV_BIT      = 1;
  localparam int          ST_IME_BIT      = 2;
  localparam int          ST_SBY_BIT      = 3;
  // control fields
  localparam int          CTRL_P1RST_BIT  = 0;
  localparam logic        CTRL_P1RST_RST  = 1'b0;
  // mode fields
  localparam int          MODE_HALT_BIT   = 0;
  localparam int          MODE_STOP_BIT   = 1;
  // flag reset values
  localparam logic        PEND_RST        = 1'b0;
  localparam logic        IME_RST         = 1'b0;
  // vectors, page and step
  localparam logic [5:0]  VEC_PAGE_IRQ    = 6'h02;
  localparam logic [5:0]  VEC_STEP_EXT    = 6'h00;
  localparam logic [5:0]  VEC_STEP_DIV    = 6'h04;
  localparam logic [5:0]  VEC_PAGE_WAKE   = 6'h03;
  localparam logic [5:0]  VEC_STEP_WAKE   = 6'h00;
  // timing
  localparam int          CLK_PERIOD_NS   = 10;
  localparam int          INSTR_CYCLE_NS  = 61000;
  localparam int          EXT_DEB_CYCLES  = 900;
  localparam logic [9:0]  EXT_DEB_LAST    = 10'(EXT_DEB_CYCLES - 1);

  typedef enum logic [2:0] {
    ISC_RUN  = 3'b001,
    ISC_HALT = 3'b010,
    ISC_STOP = 3'b100
  } isc_state_t;
endpackage : isc_pkg

// [verilog/isc_top.sv]
// Contract
// - halt instr enters halt, stop enters stop
// - halt stops clock, keeps display
// - stop stops system, blanks display
// - core state held throughout standby
// - unmasked request at entry refuses standby; code refuses ext on pin high instead of pin low
// - only reset or unmasked request releases
// - wake resumes at page 3 step 0
// - short pin low releases stop, no pending
// - port one all high resets, option on; code resets only in standby (halt or stop), not in run
// - pin sets ext pending, overflow div
// - each pending gated by own mask bit
// - ext vectors 2:0, divider vectors 2:4
// - master enable clear blocks every acceptance
// - service pulse pushes, vectors, clears enable
// - return instruction sets master enable again
// - one instruction after return before next
// - no service mid instruction or skipping
// - reset clears pendings, enable and masks
//
// Design decisions made here: the strobed register port and the register addresses.
`timescale 1ns/1ps
module isc_top #(
  parameter int unsigned CYC_CLKS = isc_pkg::INSTR_CYCLE_NS / isc_pkg::CLK_PERIOD_NS
) (
  input  wire logic                      core_clk_i,         // 100 MHz
  input  wire logic                      rstn_i,             // async reset, low
  input  wire logic [isc_pkg::ADDR_W-1:0] addr_i,            // register address
  input  wire logic [isc_pkg::DATA_W-1:0] wdata_i,           // write data
  input  wire logic                      wr_i,               // write strobe
  input  wire logic                      rd_i,               // read strobe
  output logic      [isc_pkg::DATA_W-1:0] rdata_o,           // read data, next cycle
  input  wire logic                      ext_irq_pin_i,      // external pin, async
  input  wire logic [3:0]                port_one_inputs_i,  // port 1 pins, async
  input  wire logic                      div_overflow_i,     // divider overflow pulse
  input  wire logic                      instr_boundary_i,   // core between instructions
  input  wire logic                      skip_active_i,      // core skipping
  input  wire logic                      halt_instr_i,       // halt executed, pulse
  input  wire logic                      stop_instr_i,       // stop executed, pulse
  input  wire logic                      return_from_irq_instr_instr_i,       // return from irq, pulse
  output logic                           service_o,          // push pc and jump, pulse
  output logic      [5:0]                vec_page_o,         // target page
  output logic      [5:0]                vec_step_o,         // target step
  output logic                           resume_o,           // wake jump, pulse
  output logic                           hw_reset_req_o,     // port-one reset, pulse
  output logic                           sys_clk_run_o,      // system clock running
  output logic                           system_run_o,       // system section powered
  output logic                           lcd_blank_o,        // display blanked
  output logic                           state_hold_o        // core must freeze state
);

  // instruction-cycle tick from the fast clock
  logic [15:0] cyc_cnt_ff;
  logic        tick_ff;
  wire         cyc_wrap = (cyc_cnt_ff == 16'(CYC_CLKS - 1));

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cyc_cnt_ff <= 16'h0000;
      tick_ff    <= 1'b0;
    end else begin
      cyc_cnt_ff <= cyc_wrap ? 16'h0000 : cyc_cnt_ff + 16'h0001;
      tick_ff    <= cyc_wrap;
    end
  end

  // pin synchronisers; stage one read only by stage two
  logic [4:0] sync1_ff;
  logic [4:0] sync2_ff;
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync1_ff <= 5'h1f;
      sync2_ff <= 5'h1f;
    end else begin
      sync1_ff <= {port_one_inputs_i, ext_irq_pin_i};
      sync2_ff <= sync1_ff;
    end
  end
  wire       pin_high = sync2_ff[0];
  wire [3:0] p1_sync  = sync2_ff[4:1];

  // registers
  logic [3:0]         mask_ff;
  logic               p1rst_opt_ff;
  logic               ext_pend_ff;
  logic               div_pend_ff;
  logic               ime_ff;
  logic               blk_ff;
  logic [9:0]         deb_ff;
  isc_pkg::isc_state_t state_ff;
  isc_pkg::isc_state_t nxt_state;

  wire ext_mask = mask_ff[isc_pkg::MASK_EXT_BIT];
  wire div_mask = mask_ff[isc_pkg::MASK_DIV_BIT];
  wire in_run   = (state_ff == isc_pkg::ISC_RUN);

  // bus decode
  wire wr_mask   = wr_i && (addr_i == isc_pkg::OFS_MASK);
  wire wr_status = wr_i && (addr_i == isc_pkg::OFS_STATUS);
  wire wr_ctrl   = wr_i && (addr_i == isc_pkg::OFS_CTRL);

  // low level must persist before it counts as a request
  wire deb_done = tick_ff && !pin_high && (deb_ff == isc_pkg::EXT_DEB_LAST);
  wire ext_set  = deb_done;
  wire div_set  = div_overflow_i;

  wire ext_req  = ext_pend_ff && ext_mask;
  wire div_req  = div_pend_ff && div_mask;
  wire can_take = tick_ff && instr_boundary_i && !skip_active_i
                  && !blk_ff && in_run;
  wire accept   = can_take && ime_ff && (ext_req || div_req);
  wire take_ext = accept && ext_req;
  wire take_div = accept && !ext_req;

  // entry refusal and release
  wire refuse   = (ext_mask && pin_high) || (div_mask && div_pend_ff);
  wire enter    = (halt_instr_i || stop_instr_i) && in_run && !refuse;
  wire p1_reset = !in_run && p1rst_opt_ff && (&p1_sync);
  wire wake     = !in_run && !p1_reset
                  && ((ext_mask && !pin_high) || div_req);

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      isc_pkg::ISC_RUN: begin
        if (enter) begin
          nxt_state = stop_instr_i ? isc_pkg::ISC_STOP : isc_pkg::ISC_HALT;
        end
      end
      isc_pkg::ISC_HALT, isc_pkg::ISC_STOP: begin
        if (wake || p1_reset) begin
          nxt_state = isc_pkg::ISC_RUN;
        end
      end
      default: nxt_state = isc_pkg::ISC_RUN;
    endcase
  end

  // flags: a set in the same cycle as a clear wins, except that acceptance clears the enable over a status write of 1
  wire nxt_ext_pend = (ext_pend_ff && !take_ext
                       && !(wr_status && wdata_i[isc_pkg::ST_EXT_BIT])) || ext_set;
  wire nxt_div_pend = (div_pend_ff && !take_div
                       && !(wr_status && wdata_i[isc_pkg::ST_DIV_BIT])) || div_set;
  wire nxt_ime      = return_from_irq_instr_instr_i ? 1'b1 :
                      accept       ? 1'b0 :
                      wr_status    ? wdata_i[isc_pkg::ST_IME_BIT] : ime_ff;

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mask_ff      <= isc_pkg::MASK_RST;
      p1rst_opt_ff <= isc_pkg::CTRL_P1RST_RST;
      ext_pend_ff  <= isc_pkg::PEND_RST;
      div_pend_ff  <= isc_pkg::PEND_RST;
      ime_ff       <= isc_pkg::IME_RST;
      state_ff     <= isc_pkg::ISC_RUN;
    end else begin
      if (wr_mask) begin
        mask_ff <= wdata_i & 4'h5;
      end
      if (wr_ctrl) begin
        p1rst_opt_ff <= wdata_i[isc_pkg::CTRL_P1RST_BIT];
      end
      ext_pend_ff <= nxt_ext_pend;
      div_pend_ff <= nxt_div_pend;
      ime_ff      <= nxt_ime;
      state_ff    <= nxt_state;
    end
  end

  // debounce counter saturates so one low period sets once
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      deb_ff <= 10'h000;
    end else if (pin_high) begin
      deb_ff <= 10'h000;
    end else if (tick_ff && deb_ff != 10'h3ff) begin
      deb_ff <= deb_ff + 10'h001;
    end
  end

  // hold off one instruction after a return
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      blk_ff <= 1'b0;
    end else if (return_from_irq_instr_instr_i) begin
      blk_ff <= 1'b1;
    end else if (tick_ff && instr_boundary_i && !skip_active_i) begin
      blk_ff <= 1'b0;
    end
  end

  // outputs
  wire [3:0] status_rd = {!in_run, ime_ff, div_pend_ff, ext_pend_ff};
  wire [3:0] mode_rd   = {2'b00, state_ff == isc_pkg::ISC_STOP, state_ff == isc_pkg::ISC_HALT};
  wire [3:0] rd_mux    = (addr_i == isc_pkg::OFS_MASK)   ? mask_ff :
                         (addr_i == isc_pkg::OFS_STATUS) ? status_rd :
                         (addr_i == isc_pkg::OFS_CTRL)   ? {3'b000, p1rst_opt_ff} :
                         (addr_i == isc_pkg::OFS_MODE)   ? mode_rd : 4'h0;
  wire       do_resume = wake;
  wire [5:0] nxt_page  = accept ? isc_pkg::VEC_PAGE_IRQ : isc_pkg::VEC_PAGE_WAKE;
  wire [5:0] nxt_step  = take_ext ? isc_pkg::VEC_STEP_EXT :
                         take_div ? isc_pkg::VEC_STEP_DIV : isc_pkg::VEC_STEP_WAKE;

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o        <= 4'h0;
      service_o      <= 1'b0;
      resume_o       <= 1'b0;
      hw_reset_req_o <= 1'b0;
      vec_page_o     <= 6'h00;
      vec_step_o     <= 6'h00;
      sys_clk_run_o  <= 1'b1;
      system_run_o   <= 1'b1;
      lcd_blank_o    <= 1'b0;
      state_hold_o   <= 1'b0;
    end else begin
      rdata_o        <= rd_i ? rd_mux : 4'h0;
      service_o      <= accept;
      resume_o       <= do_resume;
      hw_reset_req_o <= p1_reset;
      if (accept || do_resume) begin
        vec_page_o <= nxt_page;
        vec_step_o <= nxt_step;
      end
      sys_clk_run_o  <= (nxt_state == isc_pkg::ISC_RUN);
      system_run_o   <= (nxt_state != isc_pkg::ISC_STOP);
      lcd_blank_o    <= (nxt_state == isc_pkg::ISC_STOP);
      state_hold_o   <= (nxt_state != isc_pkg::ISC_RUN);
    end
  end

  // checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_enter_ok;
    (halt_instr_i || stop_instr_i) && in_run && !refuse;
  endsequence
  sequence s_standby_out;
    !sys_clk_run_o && state_hold_o;
  endsequence

  a_entry_to_standby:
    assert property (s_enter_ok |=> (state_ff != isc_pkg::ISC_RUN) ##0 s_standby_out)
    else $error("standby not entered");
  a_refused_entry:
    assert property ((halt_instr_i || stop_instr_i) && refuse |=> in_run)
    else $error("refused entry still went to standby");
  a_stop_blanks:
    assert property ((state_ff == isc_pkg::ISC_STOP) |-> lcd_blank_o && !system_run_o)
    else $error("stop does not blank display");
  a_halt_keeps_lcd:
    assert property ((state_ff == isc_pkg::ISC_HALT) |-> !lcd_blank_o && system_run_o && !sys_clk_run_o)
    else $error("halt outputs wrong");
  a_wake_vector:
    assert property (wake |=> resume_o && vec_page_o == isc_pkg::VEC_PAGE_WAKE
                     && vec_step_o == isc_pkg::VEC_STEP_WAKE)
    else $error("wake vector wrong");
  a_masked_no_wake:
    assert property (!in_run && !ext_mask && !div_mask && !p1_reset |=> !in_run)
    else $error("masked request released standby");
  a_no_take_ime_off:
    assert property (!ime_ff |=> !service_o)
    else $error("service without master enable");
  a_service_clears:
    assert property (accept && !return_from_irq_instr_instr_i |=> service_o && !ime_ff && vec_page_o == isc_pkg::VEC_PAGE_IRQ)
    else $error("service did not clear enable");
  a_ext_priority:
    assert property (accept && ext_req |=> vec_step_o == isc_pkg::VEC_STEP_EXT)
    else $error("external request lost priority");
  a_div_vector:
    assert property (accept && !ext_req |=> vec_step_o == isc_pkg::VEC_STEP_DIV && div_pend_ff == div_set)
    else $error("divider vector wrong");
  a_return_from_irq_instr_sets_ime:
    assert property (return_from_irq_instr_instr_i |=> ime_ff && blk_ff)
    else $error("return did not restore enable");
  a_no_take_skip:
    assert property (skip_active_i || !instr_boundary_i |=> !service_o)
    else $error("service during skip or mid instruction");
  a_pend_set_wins:
    assert property (div_set |=> div_pend_ff)
    else $error("divider pending lost");

endmodule : isc_top

// [dv/isc_core_model.sv]
`timescale 1ns/1ps
module isc_core_model (
  input  wire logic core_clk_i,       // system clock
  input  wire logic rstn_i,           // async reset, low
  input  wire logic skip_req_i,       // bench asks for a skip run
  output logic      instr_boundary_o, // core between instructions
  output logic      skip_active_o     // core skipping
);
  logic [2:0] cyc_ff;
  logic       skip_ff;
  // a two-cycle instruction every fifth clock: off the tick phase, so service is delayed, never starved
  assign instr_boundary_o = (cyc_ff != 3'h4);
  assign skip_active_o    = skip_ff;
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cyc_ff  <= 3'h0;
      skip_ff <= 1'b0;
    end else begin
      cyc_ff  <= (cyc_ff == 3'h4) ? 3'h0 : cyc_ff + 3'h1;
      skip_ff <= skip_req_i;
    end
  end
endmodule : isc_core_model

// [dv/interrupt_and_standby_control_test.sv]
`timescale 1ns/1ps
module interrupt_and_standby_control_test;
  localparam int CYC = 4;
  logic        core_clk_i = 1'b0;
  logic        rstn_i     = 1'b0;
  logic [3:0]  addr_i     = 4'h0;
  logic [3:0]  wdata_i    = 4'h0;
  logic [3:0]  port_one   = 4'h0;
  logic [3:0]  ev         = 4'h0;
  logic        wr_i       = 1'b0;
  logic        rd_i       = 1'b0;
  logic        pin        = 1'b1;
  logic        skip_req   = 1'b0;
  logic        rd_seen    = 1'b0;
  logic [3:0]  rdata_o;
  logic [5:0]  vec_page_o, vec_step_o;
  logic        service_o, resume_o, hw_reset_req_o, sys_clk_run_o, system_run_o, lcd_blank_o, state_hold_o;
  logic        boundary, skipping;
  logic [15:0] exp_q[$];
  int          n_mismatch  = 0;
  int          check_count = 0;

  always #5 core_clk_i = ~core_clk_i;

  isc_core_model i_core (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .skip_req_i(skip_req),
    .instr_boundary_o(boundary), .skip_active_o(skipping));
  isc_top #(.CYC_CLKS(CYC)) i_dut (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ext_irq_pin_i(pin), .port_one_inputs_i(port_one),
    .div_overflow_i(ev[0]), .instr_boundary_i(boundary), .skip_active_i(skipping), .halt_instr_i(ev[1]),
    .stop_instr_i(ev[2]), .return_from_irq_instr_instr_i(ev[3]), .service_o(service_o), .vec_page_o(vec_page_o),
    .vec_step_o(vec_step_o), .resume_o(resume_o), .hw_reset_req_o(hw_reset_req_o),
    .sys_clk_run_o(sys_clk_run_o), .system_run_o(system_run_o), .lcd_blank_o(lcd_blank_o),
    .state_hold_o(state_hold_o));

  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run

  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_word

  // caller samples at the falling edge, where the outputs are settled
  task automatic cmp_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_bit

  // unexpected events meet an empty queue and fail
  task automatic pop(input logic [15:0] got);
    cmp_word(got, (exp_q.size() > 0) ? exp_q.pop_front() : 16'hdead);
  endtask : pop

  always @(negedge core_clk_i) begin
    if (rd_seen) pop({4'h1, 8'h00, rdata_o});
    if (service_o) pop({4'h2, vec_page_o, vec_step_o});
    if (resume_o) pop({4'h3, vec_page_o, vec_step_o});
    if (hw_reset_req_o) pop(16'h4000);
    rd_seen = rd_i;
  end

  task automatic wr(input logic [3:0] a, input logic [3:0] d);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
    @(posedge core_clk_i);
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [3:0] d);
    exp_q.push_back({4'h1, 8'h00, d});
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    @(posedge core_clk_i);
  endtask : rd

  task automatic pulse(input logic [3:0] m);
    ev <= m;
    @(posedge core_clk_i);
    ev <= 4'h0;
    repeat (3) @(posedge core_clk_i);
  endtask : pulse

  task automatic drain(input int lim);
    for (int i = 0; i < lim && exp_q.size() > 0; i++) @(posedge core_clk_i);
    if (exp_q.size() > 0) begin
      n_mismatch++;
      complete_run();
    end
  endtask : drain

  initial begin
    repeat (20000) @(posedge core_clk_i);
    n_mismatch++;
    complete_run();
  end

  initial begin
    void'($urandom(10887));
    repeat (10) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    @(posedge core_clk_i);
    rd(4'h0, 4'h0);
    rd(4'h1, 4'h0);
    rd(4'h2, 4'h0);
    wr(4'hf, 4'($urandom));
    rd(4'hf, 4'h0);
    wr(4'h0, 4'h5);
    pulse(4'h1);
    repeat (30) @(posedge core_clk_i);
    rd(4'h1, 4'h2);
    skip_req <= 1'b1;
    wr(4'h1, 4'h4);
    repeat (30) @(posedge core_clk_i);
    rd(4'h1, 4'h6);
    exp_q.push_back({4'h2, 6'h02, 6'h04});
    skip_req <= 1'b0;
    drain(100);
    rd(4'h1, 4'h0);
    // both sources pending, external must win
    pulse(4'h1);
    pin <= 1'b0;
    repeat (901 * CYC + 8) @(posedge core_clk_i);
    pin <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    rd(4'h1, 4'h3);
    exp_q.push_back({4'h2, 6'h02, 6'h00});
    wr(4'h1, 4'h4);
    drain(100);
    rd(4'h1, 4'h2);
    exp_q.push_back({4'h2, 6'h02, 6'h04});
    pulse(4'h8);
    drain(100);
    // refused entry runs on, with no wake and no page-3 jump
    wr(4'h0, 4'h4);
    pulse(4'h1);
    pulse(4'h4);
    rd(4'h3, 4'h0);
    wr(4'h1, 4'h2);
    pulse(4'h4);
    rd(4'h3, 4'h2);
    rd(4'h1, 4'h8);
    @(negedge core_clk_i);
    cmp_bit(lcd_blank_o, 1'b1);
    cmp_bit(system_run_o, 1'b0);
    @(posedge core_clk_i);
    exp_q.push_back({4'h3, 6'h03, 6'h00});
    pulse(4'h1);
    drain(50);
    rd(4'h1, 4'h2);
    wr(4'h1, 4'h2);
    wr(4'h0, 4'h0);
    pulse(4'h2);
    rd(4'h3, 4'h1);
    @(negedge core_clk_i);
    cmp_bit(lcd_blank_o, 1'b0);
    cmp_bit(sys_clk_run_o, 1'b0);
    cmp_bit(state_hold_o, 1'b1);
    @(posedge core_clk_i);
    pulse(4'h1);
    repeat (20) @(posedge core_clk_i);
    rd(4'h3, 4'h1);
    wr(4'h2, 4'h1);
    exp_q.push_back(16'h4000);
    port_one <= 4'hf;
    drain(50);
    port_one <= 4'h0;
    rd(4'h3, 4'h0);
    drain(10);
    // short pin low releases stop but leaves the external pending clear
    wr(4'h0, 4'h1);
    pin <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    exp_q.push_back({4'h3, 6'h03, 6'h00});
    pulse(4'h4);
    drain(50);
    pin <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    rd(4'h1, 4'h2);
    drain(10);
    complete_run();
  end
endmodule : interrupt_and_standby_control_test
